// *** common/debug_port_pkg.sv ***
package debug_port_pkg;

  // ****************************************************************
  // character framing and bit-rate limits
  // ****************************************************************
  localparam int DATA_BITS     = 8;
  localparam int FRAME_BITS    = 10;
  localparam int STOP_INDEX    = 9;
  localparam int BAUD_MIN_DIV  = 512;
  localparam int CAL_LOW_BITS  = 8;
  localparam int CAL_SHIFT     = 3;
  localparam int LOW_CNT_W     = $clog2(BAUD_MIN_DIV * CAL_LOW_BITS) + 1;
  localparam int PERIOD_W      = LOW_CNT_W - CAL_SHIFT;

  // ****************************************************************
  // command codes and substitute values
  // ****************************************************************
  localparam logic [7:0]  CMD_RD_PROG     = 8'h0B;
  localparam logic [7:0]  CMD_WR_DATA     = 8'h0C;
  localparam logic [7:0]  CMD_RD_DATA     = 8'h0D;
  localparam logic [7:0]  CMD_CRC         = 8'h0E;
  localparam logic [7:0]  BLOCKED_BYTE    = 8'hFF;
  localparam logic [15:0] BLOCKED_CRC     = 16'hFFFF;
  localparam logic [15:0] CRC_INIT        = 16'hFFFF;
  localparam logic [15:0] CRC_POLY        = 16'h1021;
  localparam logic [16:0] SIZE_ZERO_BYTES = 17'h10000;
  localparam logic [16:0] CRC_REPLY_BYTES = 17'h00002;
  localparam int          PROG_BYTES_DEF  = 65536;
  localparam int          FIFO_DEPTH      = 8;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic        prog;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_cmd_t;

  typedef enum logic [3:0] {
    S_CAL_IDLE, S_CAL_LOW, S_CMD, S_AH, S_AL, S_SH, S_SL,
    S_RD, S_WR, S_CRC_START, S_CRC_RUN, S_CRC_TX
  } port_state_t;

endpackage

// *** rtl/serial_debug_command_port.sv ***
// Functional notes
// - start low, eight bits LSB first, stop high
// - after reset stay silent until host sends
// - time calibration low period, set bit rate
// - rate down to clock/512 must be measurable
// - frame: command, address high/low, size high/low
// - size zero means 65536 bytes
// - 0BH reads program memory to host
// - program read blocked returns FFH bytes
// - 0CH writes data memory, blocked discards
// - 0DH reads data memory, blocked returns FFH
// - 0EH returns CRC-CCITT of program memory
// - CRC returns FFFFH when not halted
// - CRC reply only after full computation
`timescale 1ns/10ps

// ****************************************************************
// byte buffer between the memory engine and the link
// ****************************************************************
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // full and empty come straight from the occupancy count
  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];

  // pointers wrap explicitly so a depth that is not a power of two works
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  // storage has no reset; only written slots are ever read
  always_ff @(posedge clk)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end
endmodule

// ****************************************************************
// single-pin serial debug command port
// ****************************************************************
module serial_debug_command_port #(
  parameter int PROG_BYTES = debug_port_pkg::PROG_BYTES_DEF
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     debug_serial_pin_in,
  output logic                          debug_serial_pin_out,
  output logic                          debug_serial_pin_oe,
  input  wire logic                     halted,
  input  wire logic                     read_protect,
  output logic                          mem_req,
  output debug_port_pkg::mem_cmd_t      mem_cmd,
  input  wire logic                     mem_ack,
  input  wire logic [7:0]               mem_rdata,
  output logic                          calibrated
);
  import debug_port_pkg::*;

  port_state_t          state;
  logic [2:0]           pin_sync;
  logic                 rx_line;
  logic                 line_prev;
  logic [LOW_CNT_W-1:0] low_count;
  logic [PERIOD_W-1:0]  bit_period;
  logic                 rx_active;
  logic [PERIOD_W-1:0]  rx_timer;
  logic [3:0]           rx_bit;
  logic [7:0]           rx_shift;
  logic                 rx_strobe;
  logic                 tx_busy;
  logic [FRAME_BITS-1:0] tx_shift;
  logic [PERIOD_W-1:0]  tx_timer;
  logic [3:0]           tx_cnt;
  logic [7:0]           cmd;
  logic [15:0]          addr;
  logic [7:0]           size_hi;
  logic [16:0]          remaining;
  logic [16:0]          crc_left;
  logic [15:0]          crc;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [7:0]           fifo_out_data;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    return r;
  endfunction

  // ****************************************************************
  // pin input conditioning
  // ****************************************************************
  // a change counts only once the second and third stages agree
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_sync  <= 3'h7;
      rx_line   <= 1'b1;
      line_prev <= 1'b1;
    end
    else
    begin
      pin_sync  <= {pin_sync[1:0], debug_serial_pin_in};
      line_prev <= rx_line;
      if (pin_sync[1] == pin_sync[2])
        rx_line <= pin_sync[2];
    end
  end

  // ****************************************************************
  // decode of the current step
  // ****************************************************************
  wire rx_fall     = line_prev & ~rx_line;
  wire rd_allowed  = halted & ~((cmd == CMD_RD_PROG) & read_protect);
  wire wr_allowed  = halted & ~read_protect;
  wire in_rd       = (state == S_RD);
  wire in_wr       = (state == S_WR);
  wire in_crc_tx   = (state == S_CRC_TX);
  wire rd_ack      = in_rd & mem_req & mem_ack;
  wire rd_blocked  = in_rd & ~rd_allowed & (remaining != '0);
  wire rd_issue    = in_rd & rd_allowed & (remaining != '0) & ~mem_req & fifo_in_ready;
  wire fifo_in_valid = rd_ack | rd_blocked | (in_wr & rx_strobe & (remaining != '0))
                     | (in_crc_tx & (remaining != '0));
  wire [7:0] fifo_in_data = in_wr ? rx_shift
                          : in_crc_tx ? ((remaining == CRC_REPLY_BYTES) ? crc[15:8] : crc[7:0])
                          : rd_ack ? mem_rdata : BLOCKED_BYTE;
  wire fifo_push   = fifo_in_valid & fifo_in_ready;
  wire tx_start    = (in_rd | in_crc_tx) & fifo_out_valid & ~tx_busy;
  wire wr_pop      = in_wr & fifo_out_valid & ~mem_req;
  wire fifo_out_ready = tx_start | wr_pop;
  wire rx_enable   = (state != S_CAL_IDLE) & (state != S_CAL_LOW) & ~tx_busy;
  wire reply_done  = (remaining == '0) & ~fifo_out_valid & ~tx_busy;
  wire [15:0] size_word = {size_hi, rx_shift};

  assign calibrated = (state != S_CAL_IDLE) & (state != S_CAL_LOW);

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) reply_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ****************************************************************
  // receiver: centre sampling from the calibrated period
  // ****************************************************************
  // the own echo is never heard because reception is held off while sending
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rx_active <= 1'b0;
      rx_timer  <= '0;
      rx_bit    <= '0;
      rx_shift  <= '0;
      rx_strobe <= 1'b0;
    end
    else
    begin
      rx_strobe <= 1'b0;
      if (!rx_active)
      begin
        if (rx_fall && rx_enable)
        begin
          rx_active <= 1'b1;
          rx_timer  <= bit_period >> 1;
          rx_bit    <= '0;
        end
      end
      else if (rx_timer != '0)
        rx_timer <= rx_timer - 1'b1;
      else
      begin
        rx_timer <= bit_period - 1'b1;
        rx_bit   <= rx_bit + 1'b1;
        if (rx_bit == '0)
          rx_active <= ~rx_line;                      // false start aborts
        else if (rx_bit <= 4'(DATA_BITS))
          rx_shift <= {rx_line, rx_shift[7:1]};
        else
        begin
          rx_active <= 1'b0;
          rx_strobe <= rx_line;
        end
      end
    end
  end

  // ****************************************************************
  // transmitter: ten-bit frame, pin driven only while sending
  // ****************************************************************
  assign debug_serial_pin_out = tx_shift[0];
  assign debug_serial_pin_oe  = tx_busy;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tx_busy  <= 1'b0;
      tx_shift <= '1;
      tx_timer <= '0;
      tx_cnt   <= '0;
    end
    else if (tx_start)
    begin
      tx_busy  <= 1'b1;
      tx_shift <= {1'b1, fifo_out_data, 1'b0};
      tx_timer <= bit_period - 1'b1;
      tx_cnt   <= '0;
    end
    else if (tx_busy)
    begin
      if (tx_timer != '0)
        tx_timer <= tx_timer - 1'b1;
      else if (tx_cnt == 4'(STOP_INDEX))
        tx_busy <= 1'b0;
      else
      begin
        tx_shift <= {1'b1, tx_shift[FRAME_BITS-1:1]};
        tx_cnt   <= tx_cnt + 1'b1;
        tx_timer <= bit_period - 1'b1;
      end
    end
  end

  // ****************************************************************
  // calibration, frame decoding and memory engine
  // ****************************************************************
  // one access at a time keeps ordering trivial at the cost of throughput
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state      <= S_CAL_IDLE;
      low_count  <= '0;
      bit_period <= '0;
      cmd        <= '0;
      addr       <= '0;
      size_hi    <= '0;
      remaining  <= '0;
      crc_left   <= '0;
      crc        <= CRC_INIT;
      mem_req    <= 1'b0;
      mem_cmd    <= '0;
    end
    else
    begin
      if (mem_req && mem_ack)
        mem_req <= 1'b0;
      case (state)
        S_CAL_IDLE:
          if (rx_fall)
          begin
            state     <= S_CAL_LOW;
            low_count <= LOW_CNT_W'(1);
          end
        S_CAL_LOW:
          if (rx_line)
          begin
            bit_period <= low_count[LOW_CNT_W-1:CAL_SHIFT];
            state      <= S_CMD;
          end
          else if (low_count != '1)
            low_count <= low_count + 1'b1;
        S_CMD:
          if (rx_strobe)
          begin
            cmd <= rx_shift;
            if (rx_shift == CMD_CRC)
              state <= S_CRC_START;
            else if (rx_shift == CMD_RD_PROG || rx_shift == CMD_WR_DATA ||
                     rx_shift == CMD_RD_DATA)
              state <= S_AH;
          end
        S_AH:
          if (rx_strobe)
          begin
            addr[15:8] <= rx_shift;
            state      <= S_AL;
          end
        S_AL:
          if (rx_strobe)
          begin
            addr[7:0] <= rx_shift;
            state     <= S_SH;
          end
        S_SH:
          if (rx_strobe)
          begin
            size_hi <= rx_shift;
            state   <= S_SL;
          end
        S_SL:
          if (rx_strobe)
          begin
            remaining <= (size_word == '0) ? SIZE_ZERO_BYTES : {1'b0, size_word};
            state     <= (cmd == CMD_WR_DATA) ? S_WR : S_RD;
          end
        S_RD:
        begin
          if (rd_issue)
          begin
            mem_req <= 1'b1;
            mem_cmd <= '{prog: (cmd == CMD_RD_PROG), write: 1'b0, addr: addr, wdata: 8'h00};
            addr    <= addr + 1'b1;
          end
          if (fifo_push)
            remaining <= remaining - 1'b1;
          if (reply_done)
            state <= S_CMD;
        end
        S_WR:
        begin
          if (rx_strobe && remaining != '0)
            remaining <= remaining - 1'b1;
          if (wr_pop)
          begin
            mem_req <= wr_allowed;
            mem_cmd <= '{prog: 1'b0, write: 1'b1, addr: addr, wdata: fifo_out_data};
            addr    <= addr + 1'b1;
          end
          if (remaining == '0 && !fifo_out_valid && !mem_req)
            state <= S_CMD;
        end
        S_CRC_START:
        begin
          addr     <= '0;
          crc_left <= 17'(PROG_BYTES);
          crc      <= halted ? CRC_INIT : BLOCKED_CRC;
          if (halted)
            state <= S_CRC_RUN;
          else
          begin
            remaining <= CRC_REPLY_BYTES;
            state     <= S_CRC_TX;
          end
        end
        S_CRC_RUN:
        begin
          if (crc_left == '0)
          begin
            remaining <= CRC_REPLY_BYTES;
            state     <= S_CRC_TX;
          end
          else if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_cmd <= '{prog: 1'b1, write: 1'b0, addr: addr, wdata: 8'h00};
            addr    <= addr + 1'b1;
          end
          if (mem_req && mem_ack)
          begin
            crc      <= crc_byte(crc, mem_rdata);
            crc_left <= crc_left - 1'b1;
          end
        end
        S_CRC_TX:
        begin
          if (fifo_push)
            remaining <= remaining - 1'b1;
          if (reply_done)
            state <= S_CMD;
        end
        default:
          state <= S_CAL_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  quiet_until_cal_a: assert property (@(posedge clk) disable iff (reset)
    !calibrated |-> !debug_serial_pin_oe)
    else $error("pin driven before calibration");

  start_bit_low_a: assert property (@(posedge clk) disable iff (reset)
    tx_start |=> debug_serial_pin_oe && !debug_serial_pin_out)
    else $error("start bit not low");

  stop_bit_high_a: assert property (@(posedge clk) disable iff (reset)
    tx_busy && tx_cnt == 4'(STOP_INDEX) |-> debug_serial_pin_out)
    else $error("stop bit not high");

  period_div8_a: assert property (@(posedge clk) disable iff (reset)
    state == S_CMD && $past(state) == S_CAL_LOW
      |-> bit_period == $past(low_count) >> CAL_SHIFT)
    else $error("bit period not low count over eight");

  size_zero_a: assert property (@(posedge clk) disable iff (reset)
    state == S_SL && rx_strobe && size_word == '0 |=> remaining == SIZE_ZERO_BYTES)
    else $error("size zero not taken as 65536");

  blocked_read_a: assert property (@(posedge clk) disable iff (reset)
    in_rd && !rd_allowed |-> !mem_req && (!fifo_in_valid || fifo_in_data == BLOCKED_BYTE))
    else $error("blocked read returned memory data");

  blocked_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_pop && !wr_allowed |=> !mem_req)
    else $error("blocked write reached memory");

  crc_blocked_a: assert property (@(posedge clk) disable iff (reset)
    state == S_CRC_START && !halted |=> crc == BLOCKED_CRC ##1 state == S_CRC_TX)
    else $error("blocked crc not FFFFH");

  header_quiet_a: assert property (@(posedge clk) disable iff (reset)
    state inside {S_AH, S_AL, S_SH, S_SL, S_CRC_RUN, S_WR} |-> !debug_serial_pin_oe)
    else $error("pin driven during frame or crc run");

  mem_hold_a: assert property (@(posedge clk) disable iff (reset)
    mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
    else $error("memory request dropped before ack");
endmodule

// *** verification/host_link.sv ***
`timescale 1ns/10ps

// ****************************************************************
// host debugger on the far side of the debug pin
// ****************************************************************
module host_link #(
  parameter int BIT = 20
) (
  input  wire logic clk,
  input  wire logic line,
  output logic      drv,
  output logic      tx_bit
);
  // released at start: the pull-up holds the wire high
  initial
  begin
    drv    = 1'b0;
    tx_bit = 1'b1;
  end

  // one character; the gap comes first so a reply right after the stop is not missed
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};            // start low, data LSB first, stop high
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      drv    <= 1'b1;
      tx_bit <= f[i];
      repeat (BIT - 1) @(posedge clk);
    end
    @(posedge clk);
    drv <= 1'b0;                    // never holds the pin after its stop bit
  endtask

  // wait for a start bit under a bound, then sample each bit at its centre
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    b  = 8'h00;
    while (line !== 1'b0 && n < 30000)
    begin
      @(posedge clk);
      n++;
    end
    if (n < 30000)
    begin
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(posedge clk);
        b[i] = line;
      end
      repeat (BIT) @(posedge clk);
      ok = (line === 1'b1);
    end
  endtask
endmodule

// *** verification/serial_debug_command_port_tb_top.sv ***
`timescale 1ns/10ps

module serial_debug_command_port_tb_top;
  import debug_port_pkg::*;
  localparam int PB  = 4;
  localparam int BIT = 20;          // clk/20: inside clk/512..clk/8

  logic       clk          = 1'b0;
  logic       reset        = 1'b1;
  logic       halted       = 1'b0;
  logic       read_protect = 1'b0;
  logic       mem_ack      = 1'b0;
  logic [7:0] mem_rdata    = 8'h00;
  logic       pin_out;
  logic       pin_oe;
  logic       mem_req;
  logic       calibrated;
  logic       drv;
  logic       host_bit;
  mem_cmd_t   mem_cmd;
  int         errors       = 0;
  int         n_tests      = 0;
  int         cycles       = 0;
  int         n_wr         = 0;
  int         n_prog       = 0;
  int         dly          = 0;
  int         w;
  logic [31:0] seed        = 32'h0000329B;
  logic [31:0] rv;
  logic [7:0] dmem [256];
  logic [7:0] sh [256];

  // wire level: device wins while enabled, otherwise host or pull-up
  wire line = pin_oe ? pin_out : (drv ? host_bit : 1'b1);

  always #20 clk = ~clk;

  serial_debug_command_port #(.PROG_BYTES(PB)) uut (
    .clk                  (clk),
    .reset                (reset),
    .debug_serial_pin_in  (line),
    .debug_serial_pin_out (pin_out),
    .debug_serial_pin_oe  (pin_oe),
    .halted               (halted),
    .read_protect         (read_protect),
    .mem_req              (mem_req),
    .mem_cmd              (mem_cmd),
    .mem_ack              (mem_ack),
    .mem_rdata            (mem_rdata),
    .calibrated           (calibrated)
  );

  host_link #(.BIT(BIT)) host (
    .clk    (clk),
    .line   (line),
    .drv    (drv),
    .tx_bit (host_bit)
  );

  // ****************************************************************
  // helpers and expectations
  // ****************************************************************
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] pbyte(input logic [15:0] a);
    return {a[3:0], a[7:4]} ^ 8'h3C;
  endfunction

  function automatic logic [15:0] crc_exp();
    logic [15:0] c;
    c = 16'hFFFF;
    for (int a = 0; a < PB; a++)
    begin
      c ^= {pbyte(16'(a)), 8'h00};
      for (int i = 0; i < 8; i++)
        c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
    end
    return c;
  endfunction

  // memory answers after a random wait, which tests slow and prompt replies
  always @(posedge clk)
  begin
    mem_ack <= 1'b0;
    if (mem_req === 1'b1 && mem_ack !== 1'b1)
    begin
      if (dly == 0)
      begin
        mem_ack   <= 1'b1;
        mem_rdata <= mem_cmd.prog ? pbyte(mem_cmd.addr) : dmem[mem_cmd.addr[7:0]];
        if (mem_cmd.write)
        begin
          dmem[mem_cmd.addr[7:0]] <= mem_cmd.wdata;
          n_wr++;
        end
        if (mem_cmd.prog)
          n_prog++;
        dly <= int'(rnd() & 32'h3);
      end
      else
        dly <= dly - 1;
    end
  end

  // hang guard: well above the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      errors++;
      finish_test();
    end
  end

  task check8(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task check1(input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task finish_test();
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task get(input logic [7:0] e);
    logic [7:0] b;
    logic       ok;
    host.recv(b, ok);
    check1(1'b1, ok);
    check8(e, b);
  endtask

  // one memory frame; data reply bytes are judged against the shadow copy, program bytes against pbyte, blocked ones against BLOCKED_BYTE
  task cmd(input logic [7:0] c, input logic [15:0] a, input int n, input logic h, input logic p);
    logic [7:0] d;
    @(posedge clk);
    halted       <= h;
    read_protect <= p;
    host.send(c);
    host.send(a[15:8]);
    host.send(a[7:0]);
    host.send(8'(n >> 8));
    host.send(8'(n));
    for (int i = 0; i < n; i++)
    begin
      if (c == CMD_WR_DATA)
      begin
        d = 8'(rnd());
        host.send(d);
        if (h && !p)
          sh[8'(a + i)] = d;
      end
      else if (c == CMD_RD_PROG)
        get((h && !p) ? pbyte(16'(a + i)) : BLOCKED_BYTE);
      else
        get(h ? sh[8'(a + i)] : BLOCKED_BYTE);
    end
    repeat (4 * BIT) @(posedge clk);
    $display("test cmd %h size %0d done", c, n);
  endtask

  task crc(input logic h);
    logic [15:0] e;
    e = h ? crc_exp() : BLOCKED_CRC;
    @(posedge clk);
    halted <= h;
    w = n_prog;
    host.send(CMD_CRC);
    get(e[15:8]);
    check8(h ? 8'(PB) : 8'h00, 8'(n_prog - w));
    get(e[7:0]);
    $display("test crc %0d done", h);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      dmem[i] = 8'(i * 7);
      sh[i]   = 8'(i * 7);
    end
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (40) @(posedge clk) check1(1'b0, pin_oe);
    check1(1'b0, calibrated);
    host.send(8'h80);
    repeat (2 * BIT) @(posedge clk);
    check1(1'b1, calibrated);
    $display("test calibration done");
    cmd(CMD_RD_DATA, 16'h00FF, 1, 1'b1, 1'b0);
    cmd(CMD_WR_DATA, 16'h0010, 3, 1'b1, 1'b0);
    cmd(CMD_RD_DATA, 16'h0010, 3, 1'b1, 1'b1);
    w = n_wr;
    cmd(CMD_WR_DATA, 16'h0010, 2, 1'b1, 1'b1);
    check8(8'(w), 8'(n_wr));
    w = n_wr;
    cmd(CMD_WR_DATA, 16'h0011, 2, 1'b0, 1'b0);
    check8(8'(w), 8'(n_wr));
    cmd(CMD_RD_PROG, 16'h1234, 2, 1'b1, 1'b0);
    cmd(CMD_RD_PROG, 16'h1234, 2, 1'b1, 1'b1);
    cmd(CMD_RD_PROG, 16'hFFFF, 1, 1'b0, 1'b0);
    cmd(CMD_RD_DATA, 16'h0010, 2, 1'b0, 1'b0);
    host.send(8'h0A);
    cmd(CMD_RD_DATA, 16'h0012, 1, 1'b1, 1'b0);
    crc(1'b1);
    crc(1'b0);
    // size zero keeps the port taking bytes; a second reset then cuts the frame
    cmd(CMD_WR_DATA, 16'h0040, 0, 1'b1, 1'b0);
    w = n_wr;
    host.send(8'hA5);
    host.send(8'h5A);
    sh[8'h40] = 8'hA5;
    sh[8'h41] = 8'h5A;
    repeat (4 * BIT) @(posedge clk);
    check8(8'(w + 2), 8'(n_wr));
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (20) @(posedge clk) check1(1'b0, pin_oe);
    check1(1'b0, calibrated);
    host.send(8'h80);
    repeat (2 * BIT) @(posedge clk);
    check1(1'b1, calibrated);
    cmd(CMD_RD_DATA, 16'h0040, 2, 1'b1, 1'b0);
    $display("test size zero and reset done");
    // one draw per frame keeps the sequence independent of argument order
    for (int k = 0; k < 8; k++)
    begin
      rv = rnd();
      cmd(8'h0B + 8'(rv % 3), rv[31:16], 1 + int'(rv[9:8] % 3), rv[4], rv[5]);
    end
    finish_test();
  end
endmodule
